// *** hw/gmc_gauge_cmd.sv ***
`timescale 1ns/1ps

// Summary of operation
// - low eight bits pick ceiling speed entry
// - index above table top uses table top
// - faster gauge defers new ceiling until slower
// - bits 8 and 9 pick gauges
// - ceiling holds until next addressed command
// - address 010 loads gauge 0 target
// - address 011 loads gauge 1 target
// - zero return uses full single-coil steps
// - integrate back voltage into 15-bit accumulator
// - bit 0 picks gauge, bit 1 enables
// - bits 3:2 choose accumulator status window
// - window may change during zero return
// - report previous step, first step all ones
// - bit 4 unconditional, else stop on stall
// - chip select rise latches word by address
// - negative accumulator after step means stall
module gmc_gauge_cmd #(
    parameter int FULL_STEP_CYCLES = gmc_pkg::FULL_STEP_CYC,
    parameter int SPEED_UNIT       = gmc_pkg::SPEED_UNIT_CYC,
    parameter int SAMPLE_CYCLES    = gmc_pkg::SAMPLE_CYC
) (
    // system
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // serial link
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_si,
    output logic             o_so,
    output logic             o_so_oe,
    // back voltage comparator
    input  wire logic        i_back_voltage,
    // gauge state
    output logic [11:0]      o_pos0,
    output logic [11:0]      o_pos1,
    output logic [7:0]       o_ceiling0,
    output logic [7:0]       o_ceiling1,
    output logic [1:0]       o_moving,
    output logic [1:0]       o_zero_busy,
    output logic [1:0]       o_coil
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic cmd_ok(input logic [15:0] w);
        logic [2:0] a;
        a = w[gmc_pkg::ADDR_MSB:gmc_pkg::ADDR_LSB];
        case (a)
            gmc_pkg::ADDR_MAX_SPEED:
                cmd_ok = (w[gmc_pkg::SPD_ZERO_MSB:gmc_pkg::SPD_ZERO_LSB] == 3'h0);
            gmc_pkg::ADDR_TARGET0, gmc_pkg::ADDR_TARGET1:
                cmd_ok = !w[gmc_pkg::POS_ZERO_BIT];
            gmc_pkg::ADDR_ZERO_RET:
                cmd_ok = (w[gmc_pkg::ZR_ZERO_MSB:gmc_pkg::ZR_ZERO_LSB] == 8'h00);
            default:
                cmd_ok = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] clamp_index(input logic [7:0] idx);
        if (idx == 8'h00)
            clamp_index = 8'h01;
        else if (idx > gmc_pkg::TABLE_TOP)
            clamp_index = gmc_pkg::TABLE_TOP;
        else
            clamp_index = idx;
    endfunction

    function automatic logic [31:0] step_period(input logic [7:0] spd);
        step_period = (32'(gmc_pkg::TABLE_TOP) + 32'h1 - 32'(spd)) * 32'(SPEED_UNIT);
    endfunction

    function automatic logic [7:0] acc_window(input logic [1:0] sel, input logic [14:0] acc);
        case (sel)
            gmc_pkg::WIN_LOW: acc_window = acc[7:0];
            gmc_pkg::WIN_MID: acc_window = acc[11:4];
            default:          acc_window = {1'b0, acc[14:8]};
        endcase
    endfunction

    // ----------------------------------------------------------------
    // link domain: receive
    // ----------------------------------------------------------------
    logic        rx_fresh;
    logic [15:0] rx_shift;
    logic [3:0]  rx_cnt;
    logic        rx_whole;
    logic        rx_tgl;
    logic [3:0]  next_rx_cnt;

    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n)
            rx_fresh <= 1'b1;
        else
            rx_fresh <= 1'b0;
    end

    assign next_rx_cnt = rx_fresh ? 4'h1 : rx_cnt + 4'h1;

    always_ff @(negedge i_sclk) begin
        rx_shift <= {rx_shift[14:0], i_si};
        rx_cnt   <= next_rx_cnt;
        rx_whole <= (next_rx_cnt == 4'h0);
    end

    // frame toggle needs a known start or no word is ever taken
    always_ff @(negedge i_sclk or posedge i_rst) begin
        if (i_rst)
            rx_tgl <= 1'b0;
        else if (rx_fresh)
            rx_tgl <= !rx_tgl;
    end

    // ----------------------------------------------------------------
    // link domain: transmit
    // ----------------------------------------------------------------
    logic        tx_fresh;
    logic [15:0] tx_shift;
    logic [15:0] status_hold;

    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n)
            tx_fresh <= 1'b1;
        else
            tx_fresh <= 1'b0;
    end

    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n)
            tx_shift <= 16'h0000;
        else if (tx_fresh)
            tx_shift <= status_hold;
        else
            tx_shift <= {tx_shift[14:0], rx_shift[0]};
    end

    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n)
            o_so_oe <= 1'b0;
        else
            o_so_oe <= 1'b1;
    end

    assign o_so = tx_shift[15];

    // ----------------------------------------------------------------
    // system domain: crossing
    // ----------------------------------------------------------------
    logic [2:0]  cs_sync;
    logic        cs_level;
    logic [1:0]  tgl_sync;
    logic        tgl_seen;
    logic        cs_rise;
    logic [2:0]  bv_sync;
    logic        bv_level;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cs_sync  <= 3'h7;
            cs_level <= 1'b1;
            tgl_sync <= 2'h0;
            bv_sync  <= 3'h0;
            bv_level <= 1'b0;
        end else begin
            cs_sync  <= {cs_sync[1:0], i_cs_n};
            tgl_sync <= {tgl_sync[0], rx_tgl};
            bv_sync  <= {bv_sync[1:0], i_back_voltage};
            if (cs_sync[1] == cs_sync[2])
                cs_level <= cs_sync[2];
            if (bv_sync[1] == bv_sync[2])
                bv_level <= bv_sync[2];
        end
    end

    assign cs_rise = cs_sync[1] && cs_sync[2] && !cs_level;

    // ----------------------------------------------------------------
    // system domain: command latch
    // ----------------------------------------------------------------
    logic        cmd_stb;
    logic [15:0] cmd_word;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            tgl_seen <= 1'b0;
            cmd_stb  <= 1'b0;
            cmd_word <= 16'h0000;
        end else begin
            cmd_stb <= 1'b0;
            if (cs_rise) begin
                tgl_seen <= tgl_sync[1];
                if (rx_whole && (tgl_sync[1] != tgl_seen) && cmd_ok(rx_shift)) begin
                    cmd_stb  <= 1'b1;
                    cmd_word <= rx_shift;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // system domain: ceilings and targets
    // ----------------------------------------------------------------
    logic [7:0]  ceil_req  [2];
    logic [7:0]  ceil      [2];
    logic [11:0] target    [2];
    logic [11:0] pos       [2];
    logic [7:0]  speed     [2];
    logic [31:0] step_tmr  [2];
    logic        zero_busy [2];
    logic        zr_gauge;
    logic [1:0]  win_sel;
    logic        unconditional;
    logic        step_end;
    logic        stall;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int g = 0; g < 2; g++) begin
                ceil_req[g] <= gmc_pkg::SPEED_RESET;
                ceil[g]     <= gmc_pkg::SPEED_RESET;
            end
        end else begin
            for (int g = 0; g < 2; g++) begin
                if (cmd_stb && cmd_word[15:13] == gmc_pkg::ADDR_MAX_SPEED
                        && cmd_word[gmc_pkg::SPD_APPLY0_BIT + g])
                    ceil_req[g] <= clamp_index(cmd_word[7:0]);
                if (speed[g] <= ceil_req[g])
                    ceil[g] <= ceil_req[g];
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            target[0] <= gmc_pkg::POS_RESET;
            target[1] <= gmc_pkg::POS_RESET;
        end else if (cmd_stb) begin
            if (cmd_word[15:13] == gmc_pkg::ADDR_TARGET0)
                target[0] <= cmd_word[gmc_pkg::POS_MSB:0];
            if (cmd_word[15:13] == gmc_pkg::ADDR_TARGET1)
                target[1] <= cmd_word[gmc_pkg::POS_MSB:0];
        end
    end

    // ----------------------------------------------------------------
    // system domain: pointer motion
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int g = 0; g < 2; g++) begin
                pos[g]      <= gmc_pkg::POS_RESET;
                speed[g]    <= 8'h00;
                step_tmr[g] <= 32'h0;
            end
        end else begin
            for (int g = 0; g < 2; g++) begin
                if (zero_busy[g]) begin
                    speed[g] <= 8'h00;
                    if (step_end && zr_gauge == g[0]) begin
                        if (stall || pos[g] < 12'(gmc_pkg::USTEP_PER_FULL))
                            pos[g] <= 12'h000;
                        else
                            pos[g] <= pos[g] - 12'(gmc_pkg::USTEP_PER_FULL);
                    end
                end else if (pos[g] == target[g]) begin
                    speed[g]    <= 8'h00;
                    step_tmr[g] <= 32'h0;
                end else if (step_tmr[g] != 32'h0) begin
                    step_tmr[g] <= step_tmr[g] - 32'h1;
                end else begin
                    pos[g] <= (pos[g] < target[g]) ? pos[g] + 12'h1 : pos[g] - 12'h1;
                    if (speed[g] < ceil[g])
                        speed[g] <= speed[g] + 8'h1;
                    else if (speed[g] > ceil[g])
                        speed[g] <= speed[g] - 8'h1;
                    step_tmr[g] <= step_period(speed[g]);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // system domain: zero return control
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            zero_busy[0]  <= 1'b0;
            zero_busy[1]  <= 1'b0;
            zr_gauge      <= 1'b0;
            win_sel       <= gmc_pkg::WIN_LOW;
            unconditional <= 1'b0;
        end else if (cmd_stb && cmd_word[15:13] == gmc_pkg::ADDR_ZERO_RET) begin
            win_sel       <= cmd_word[gmc_pkg::ZR_WIN_MSB:gmc_pkg::ZR_WIN_LSB];
            unconditional <= cmd_word[gmc_pkg::ZR_UNCOND_BIT];
            zr_gauge      <= cmd_word[gmc_pkg::ZR_SEL_BIT];
            zero_busy[cmd_word[gmc_pkg::ZR_SEL_BIT]] <= cmd_word[gmc_pkg::ZR_EN_BIT];
            zero_busy[!cmd_word[gmc_pkg::ZR_SEL_BIT]] <= 1'b0;
        end else if (step_end && stall) begin
            zero_busy[zr_gauge] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // system domain: full step timing and integration
    // ----------------------------------------------------------------
    logic [31:0] fs_cnt;
    logic [31:0] smp_cnt;
    logic [14:0] acc;
    logic [14:0] acc_done;
    logic        zr_active;
    logic        zr_was;

    assign zr_active = zero_busy[0] || zero_busy[1];
    assign step_end  = zr_active && (fs_cnt == 32'(FULL_STEP_CYCLES - 1));
    assign stall     = !unconditional && acc[gmc_pkg::ACC_BITS - 1];

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            fs_cnt  <= 32'h0;
            smp_cnt <= 32'h0;
            zr_was  <= 1'b0;
            o_coil  <= 2'h0;
        end else begin
            zr_was <= zr_active;
            if (!zr_active || step_end) begin
                fs_cnt  <= 32'h0;
                smp_cnt <= 32'h0;
            end else begin
                fs_cnt  <= fs_cnt + 32'h1;
                smp_cnt <= (smp_cnt == 32'(SAMPLE_CYCLES - 1)) ? 32'h0 : smp_cnt + 32'h1;
            end
            if (!zr_active)
                o_coil <= 2'h0;
            else if (!zr_was || step_end)
                o_coil <= (o_coil == 2'h1) ? 2'h2 : 2'h1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            acc      <= gmc_pkg::ACC_INIT;
            acc_done <= gmc_pkg::ACC_FIRST;
        end else if (!zr_active) begin
            acc <= gmc_pkg::ACC_INIT;
            if (!zr_was)
                acc_done <= gmc_pkg::ACC_FIRST;
        end else if (step_end) begin
            acc_done <= acc;
            acc      <= gmc_pkg::ACC_INIT;
        end else if (smp_cnt == 32'h0) begin
            acc <= bv_level ? acc + 15'h1 : acc - 15'h1;
        end
    end

    // ----------------------------------------------------------------
    // status snapshot and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst)
            status_hold <= 16'h0000;
        else if (cs_level && cs_sync[2])
            status_hold <= {acc_window(win_sel, acc_done), zero_busy[1], zero_busy[0],
                            o_moving, 4'h0};
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_moving    <= 2'h0;
            o_zero_busy <= 2'h0;
        end else begin
            o_moving    <= {pos[1] != target[1], pos[0] != target[0]};
            o_zero_busy <= {zero_busy[1], zero_busy[0]};
        end
    end

    assign o_pos0     = pos[0];
    assign o_pos1     = pos[1];
    assign o_ceiling0 = ceil[0];
    assign o_ceiling1 = ceil[1];

endmodule // gmc_gauge_cmd

// *** hw/gmc_pkg.sv ***
package gmc_pkg;

    // ----------------------------------------------------------------
    // serial word layout
    // ----------------------------------------------------------------
    localparam int         WORD_BITS      = 16;
    localparam int         ADDR_MSB       = 15;
    localparam int         ADDR_LSB       = 13;
    localparam int         DATA_BITS      = 13;

    // ----------------------------------------------------------------
    // command addresses
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_MAX_SPEED = 3'h1;
    localparam logic [2:0] ADDR_TARGET0   = 3'h2;
    localparam logic [2:0] ADDR_TARGET1   = 3'h3;
    localparam logic [2:0] ADDR_ZERO_RET  = 3'h4;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int         SPD_IDX_LSB    = 0;
    localparam int         SPD_IDX_MSB    = 7;
    localparam int         SPD_APPLY0_BIT = 8;
    localparam int         SPD_APPLY1_BIT = 9;
    localparam int         SPD_ZERO_LSB   = 10;
    localparam int         SPD_ZERO_MSB   = 12;
    localparam int         POS_MSB        = 11;
    localparam int         POS_ZERO_BIT   = 12;
    localparam int         ZR_SEL_BIT     = 0;
    localparam int         ZR_EN_BIT      = 1;
    localparam int         ZR_WIN_LSB     = 2;
    localparam int         ZR_WIN_MSB     = 3;
    localparam int         ZR_UNCOND_BIT  = 4;
    localparam int         ZR_ZERO_LSB    = 5;
    localparam int         ZR_ZERO_MSB    = 12;

    // ----------------------------------------------------------------
    // accumulator window encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] WIN_LOW        = 2'h0;
    localparam logic [1:0] WIN_MID        = 2'h1;

    // ----------------------------------------------------------------
    // widths and reset values
    // ----------------------------------------------------------------
    localparam int         POS_BITS       = 12;
    localparam int         SPEED_BITS     = 8;
    localparam int         ACC_BITS       = 15;
    localparam logic [7:0] SPEED_RESET    = 8'h01;
    localparam logic [11:0] POS_RESET     = 12'h000;
    localparam logic [14:0] ACC_INIT      = 15'h7FFF;
    localparam logic [14:0] ACC_FIRST     = 15'h7FFF;
    localparam logic [7:0] TABLE_TOP      = 8'hFF;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int         CLOCK_MHZ      = 100;
    localparam int         FULL_STEP_US   = 21250;
    localparam int         FULL_STEP_CYC  = FULL_STEP_US * CLOCK_MHZ;
    localparam int         SPEED_UNIT_US  = 10;
    localparam int         SPEED_UNIT_CYC = SPEED_UNIT_US * CLOCK_MHZ;
    localparam int         SAMPLE_US      = 10;
    localparam int         SAMPLE_CYC     = SAMPLE_US * CLOCK_MHZ;
    localparam int         USTEP_PER_FULL = 6;

endpackage

// *** tb/gmc_gauge_cmd_sva.sv ***
`timescale 1ns/1ps

module gmc_gauge_cmd_sva (
    // system
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // serial link
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_si,
    input  wire logic        o_so,
    input  wire logic        o_so_oe,
    input  wire logic        i_back_voltage,
    // gauge state
    input  wire logic [11:0] o_pos0,
    input  wire logic [11:0] o_pos1,
    input  wire logic [7:0]  o_ceiling0,
    input  wire logic [7:0]  o_ceiling1,
    input  wire logic [1:0]  o_moving,
    input  wire logic [1:0]  o_zero_busy,
    input  wire logic [1:0]  o_coil
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence busy_run;
        (|o_zero_busy) [*4];
    endsequence

    sequence frame_closed;
        i_cs_n && $past(i_cs_n, 4);
    endsequence

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    coil_onehot_a: assert property ($onehot0(o_coil))
        else $error("both coils driven");
    coil_drive_a: assert property (busy_run |-> $onehot($past(o_coil)))
        else $error("zero return without single driven coil");
    busy_single_a: assert property (o_zero_busy != 2'b11)
        else $error("zero return on both gauges");
    ceiling_valid_a: assert property (o_ceiling0 != 8'h00 && o_ceiling1 != 8'h00)
        else $error("ceiling index zero");
    so_release_a: assert property (i_cs_n |-> !o_so_oe && !o_so)
        else $error("serial output driven while deselected");
    zero_start_a: assert property ($rose(o_zero_busy[0]) || $rose(o_zero_busy[1]) |-> frame_closed)
        else $error("zero return started without a finished frame");
    pos0_quiet_a: assert property (!o_moving[0] && !o_zero_busy[0] && !$past(o_zero_busy[0])
        |-> $stable(o_pos0))
        else $error("gauge 0 position moved while idle");
    pos1_quiet_a: assert property (!o_moving[1] && !o_zero_busy[1] && !$past(o_zero_busy[1])
        |-> $stable(o_pos1))
        else $error("gauge 1 position moved while idle");
endmodule // gmc_gauge_cmd_sva

// *** tb/gmc_host_model.sv ***
`timescale 1ns/1ps

module gmc_host_model (
    // serial return path
    input  wire logic i_so,
    input  wire logic i_so_oe,
    // serial drive
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_si
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si   = 1'b1;
    end

    // shifts n bits msb first from the top of bits, returns the bits read back
    task automatic frame(input logic [31:0] bits, input int n, output logic [31:0] rx);
        logic [31:0] sh;
        sh = bits;
        rx = 32'h0;
        o_cs_n = 1'b0;
        #60;
        for (int k = 0; k < n; k++) begin
            o_si = sh[31];
            o_sclk = 1'b1;
            #6;
            o_sclk = 1'b0;
            rx = {rx[30:0], i_so};
            sh = {sh[30:0], 1'b0};
            #6;
        end
        o_cs_n = 1'b1;
        o_si = ~o_si;
        #80;
    endtask
endmodule // gmc_host_model

// *** tb/test_gmc_gauge_cmd.sv ***
`timescale 1ns/1ps

module test_gmc_gauge_cmd;
    logic        i_clock;
    logic        i_rst;
    logic        i_sclk;
    logic        i_cs_n;
    logic        i_si;
    logic        i_back_voltage;
    logic        o_so;
    logic        o_so_oe;
    logic [11:0] o_pos0;
    logic [11:0] o_pos1;
    logic [7:0]  o_ceiling0;
    logic [7:0]  o_ceiling1;
    logic [1:0]  o_moving;
    logic [1:0]  o_zero_busy;
    logic [1:0]  o_coil;
    logic [31:0] rx;
    int          miscompares;
    int          checks;

    gmc_gauge_cmd #(.FULL_STEP_CYCLES(200), .SPEED_UNIT(2), .SAMPLE_CYCLES(4)) gmc_gauge_cmd_i (
        .i_clock(i_clock), .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_si(i_si),
        .o_so(o_so), .o_so_oe(o_so_oe), .i_back_voltage(i_back_voltage),
        .o_pos0(o_pos0), .o_pos1(o_pos1), .o_ceiling0(o_ceiling0), .o_ceiling1(o_ceiling1),
        .o_moving(o_moving), .o_zero_busy(o_zero_busy), .o_coil(o_coil));

    gmc_host_model gmc_host_model_i (
        .i_so(o_so), .i_so_oe(o_so_oe), .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_si(i_si));

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [15:0] w);
        gmc_host_model_i.frame({w, 16'h0000}, 16, rx);
        repeat (12) @(negedge i_clock);
    endtask

    // waits for gauge g to finish zero return, and motion too unless zr
    task automatic settle(input int g, input bit zr, input int limit);
        int n;
        n = 0;
        while ((o_zero_busy[g] !== 1'b0 || (!zr && o_moving[g] !== 1'b0)) && n < limit) begin
            @(negedge i_clock);
            n++;
        end
        chk(16'(n < limit), 16'h0001);
        repeat (4) @(negedge i_clock);
    endtask

    task summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        i_rst = 1'b1;
        i_back_voltage = 1'b0;
        miscompares = 0;
        checks = 0;
        repeat (4) @(negedge i_clock);
        i_rst = 1'b0;
        repeat (6) @(negedge i_clock);
        chk(16'(o_ceiling0), 16'h0001);
        chk(16'(o_pos0), 16'h0000);
        chk(16'(o_zero_busy), 16'h0000);
        cmd(16'h2364);
        chk(16'(o_ceiling0), 16'h0064);
        chk(16'(o_ceiling1), 16'h0064);
        cmd(16'h2220);
        chk(16'(o_ceiling0), 16'h0064);
        chk(16'(o_ceiling1), 16'h0020);
        cmd(16'h2733);
        chk(16'(o_ceiling1), 16'h0020);
        cmd(16'h23FF);
        chk(16'(o_ceiling0), 16'h00FF);
        gmc_host_model_i.frame(32'h23050000, 8, rx);
        repeat (12) @(negedge i_clock);
        chk(16'(o_ceiling0), 16'h00FF);
        cmd(16'h5002);
        chk(16'(o_moving), 16'h0000);
        cmd(16'h4003);
        chk(16'(o_moving[0]), 16'h0001);
        settle(0, 1'b0, 4000);
        chk(16'(o_pos0), 16'h0003);
        cmd(16'h6002);
        settle(1, 1'b0, 4000);
        chk(16'(o_pos1), 16'h0002);
        cmd(16'h4010);
        repeat (2000) @(negedge i_clock);
        cmd(16'h2101);
        chk(16'(o_ceiling0), 16'h00FF);
        settle(0, 1'b0, 20000);
        chk(16'(o_ceiling0), 16'h0001);
        chk(16'(o_pos0), 16'h0010);
        cmd(16'h8022);
        chk(16'(o_zero_busy), 16'h0000);
        cmd(16'h4000);
        cmd(16'h8002);
        chk(16'(o_zero_busy), 16'h0001);
        cmd(16'hC000);
        chk(16'(rx[15:8]), 16'h00FF);
        chk(16'(rx[6]), 16'h0001);
        settle(0, 1'b1, 1000);
        chk(16'(o_pos0), 16'h0000);
        cmd(16'h8012);
        repeat (700) @(negedge i_clock);
        chk(16'(o_zero_busy), 16'h0001);
        cmd(16'h801A);
        cmd(16'hC000);
        chk(16'(rx[15:8]), 16'h007F);
        cmd(16'h8016);
        cmd(16'hC000);
        chk(16'(rx[15:12]), 16'h000F);
        chk(16'(o_zero_busy), 16'h0001);
        cmd(16'h8010);
        chk(16'(o_zero_busy), 16'h0000);
        i_back_voltage = 1'b1;
        cmd(16'h8003);
        chk(16'(o_zero_busy), 16'h0002);
        repeat (500) @(negedge i_clock);
        chk(16'(o_zero_busy), 16'h0002);
        cmd(16'hC000);
        chk(16'(rx[15:8]), 16'h0031);
        i_back_voltage = 1'b0;
        cmd(16'h8001);
        chk(16'(o_zero_busy), 16'h0000);
        gmc_host_model_i.frame(32'hC0002305, 32, rx);
        repeat (12) @(negedge i_clock);
        chk(rx[15:0], 16'hC000);
        chk(16'(o_ceiling0), 16'h0005);
        summarize();
    end

    initial begin
        repeat (100000) @(posedge i_clock);
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end
endmodule // test_gmc_gauge_cmd

bind gmc_gauge_cmd gmc_gauge_cmd_sva gmc_gauge_cmd_sva_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_si(i_si),
    .o_so(o_so), .o_so_oe(o_so_oe), .i_back_voltage(i_back_voltage),
    .o_pos0(o_pos0), .o_pos1(o_pos1), .o_ceiling0(o_ceiling0), .o_ceiling1(o_ceiling1),
    .o_moving(o_moving), .o_zero_busy(o_zero_busy), .o_coil(o_coil));
